// >>> cable_pkg.sv
/*
 * constants, timing counts and register layout for the cable status and
 * configuration clock select block.
 * assumes a single 20 MHz core clock and a 32-bit axi4-lite register bus.
 */
`default_nettype none

package cable_pkg;

  // core clock
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;

  // register bus
  localparam int unsigned ADDR_W      = 4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // control register fields
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_SEL_W    = 3;
  localparam int unsigned CTRL_IDENT    = 3;
  localparam int unsigned CTRL_FWUPD    = 4;
  localparam int unsigned CTRL_CONNECT  = 5;

  // status register fields
  localparam int unsigned ST_RED   = 0;
  localparam int unsigned ST_GREEN = 1;
  localparam int unsigned ST_VREF  = 2;
  localparam int unsigned ST_HOST  = 3;
  localparam int unsigned ST_SUSP  = 4;
  localparam int unsigned ST_CONN  = 5;
  localparam int unsigned ST_DROP  = 6;

  // clock selections: 24, 12, 6, 3, 1.5 MHz and 750 kHz
  localparam logic [2:0]  SEL_NUM     = 3'h6;
  localparam logic [2:0]  SEL_RST     = 3'h2;
  localparam int unsigned NCO_W       = 24;

  // reset values
  localparam logic        IDENT_RST   = 1'b0;
  localparam logic        FWUPD_RST   = 1'b0;
  localparam logic        CONN_RST    = 1'b0;

  // timing
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_W        = 23;
  localparam int unsigned HOST_LOST_NS   = 2000;
  localparam int unsigned HOST_LOST_CYC  =
    (HOST_LOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOST_W         = 6;

  // selection code to frequency in kHz
  function automatic int unsigned sel_khz(input logic [2:0] sel);
    unique case (sel)
      3'h0:    sel_khz = 24000;
      3'h1:    sel_khz = 12000;
      3'h2:    sel_khz = 6000;
      3'h3:    sel_khz = 3000;
      3'h4:    sel_khz = 1500;
      default: sel_khz = 750;
    endcase
  endfunction

  // phase step per core cycle for twice the selected rate
  function automatic logic [NCO_W:0] nco_step(input logic [2:0] sel);
    longint unsigned s;
    s = (longint'(sel_khz(sel)) * 2 * (64'h1 << NCO_W)) / (CLK_HZ / 1000);
    if (s > (64'h1 << NCO_W)) begin
      s = 64'h1 << NCO_W;
    end
    nco_step = s[NCO_W:0];
  endfunction

endpackage

`default_nettype wire

// >>> cable_status_clk.sv
/*
 * cable status indicator and configuration clock selection, with an
 * axi4-lite register slave.
 * assumes comparator, suspend and host link clock pins are asynchronous;
 * the bus runs on the core clock.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - serial clock runs at 24, 12, 6, 3, 1.5 MHz or 750 kHz only; the 24 and 12 MHz selections saturate at 10 MHz here.
// RULE2 - after reset the serial clock selection is 6 MHz.
// RULE3 - every one of the six selections is accepted without restriction.
// RULE4 - host offers only chain-safe rates, 6 MHz or highest common by default.
// RULE5 - amber when no target, unpowered target, or reference at most 1.3V.
// RULE6 - green only with attached powered target and reference at least 1.5V.
// RULE7 - 200 mV hysteresis: amber after falling below 1.3V until above 1.5V.
// RULE8 - steady red throughout a firmware update.
// RULE9 - dark when suspended, host port gone or host port unpowered.
// RULE10 - identification makes the current amber or green colour blink.
// RULE11 - target output drivers are unpowered during host suspend.
// RULE12 - suspend drops the host connection; host reconnects after resume.
// RULE13 - priority: dark, then red, then green or amber, blinking on top.
// RULE14 - comparator levels are synchronised to the core clock before use.
module cable_status_clk
  import cable_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  // reference voltage comparators and host state
  input  wire logic              vref_above_hi_in,
  input  wire logic              vref_below_lo_in,
  input  wire logic              host_suspend_in,
  input  wire logic              host_link_clk_in,
  // target side
  output var  logic              config_serial_clock_out,
  output var  logic              target_drv_pwr_out,
  // indicator, amber is red and green together
  output var  logic              led_red_out,
  output var  logic              led_green_out,
  // axi4-lite write address and data
  input  wire logic              axi_awvalid_in,
  input  wire logic [ADDR_W-1:0] axi_awaddr_in,
  output var  logic              axi_awready_out,
  input  wire logic              axi_wvalid_in,
  input  wire logic [31:0]       axi_wdata_in,
  input  wire logic [3:0]        axi_wstrb_in,
  output var  logic              axi_wready_out,
  // axi4-lite write response
  output var  logic              axi_bvalid_out,
  output var  logic [1:0]        axi_bresp_out,
  input  wire logic              axi_bready_in,
  // axi4-lite read
  input  wire logic              axi_arvalid_in,
  input  wire logic [ADDR_W-1:0] axi_araddr_in,
  output var  logic              axi_arready_out,
  output var  logic              axi_rvalid_out,
  output var  logic [31:0]       axi_rdata_out,
  output var  logic [1:0]        axi_rresp_out,
  input  wire logic              axi_rready_in
);

  typedef enum logic [1:0] {
    LED_OFF,
    LED_AMBER,
    LED_GREEN,
    LED_RED
  } led_t;

  // synchronised pins
  logic [3:0] pins_s;
  logic       above_s;
  logic       below_s;
  logic       suspend_s;
  logic       link_s;

  cable_sync2 #(
    .W (4)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .async_in    ({host_link_clk_in, host_suspend_in,
                   vref_below_lo_in, vref_above_hi_in}),
    .sync_out    (pins_s)
  ); // RULE14

  assign above_s   = pins_s[0];
  assign below_s   = pins_s[1];
  assign suspend_s = pins_s[2];
  assign link_s    = pins_s[3];

  // control state
  logic [2:0]        clk_sel_q;
  logic              ident_q;
  logic              fwupd_q;
  logic              conn_q;
  logic              drop_q;
  logic              vref_ok_q;
  logic              link_d1_q;
  logic [HOST_W-1:0] host_cnt_q;
  logic              host_up_q;
  logic [BLINK_W-1:0] blink_cnt_q;
  logic              blink_ph_q;
  logic              drv_pwr_q;

  // axi state
  logic              awready_q;
  logic              wready_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // bus decode
  wire aw_take  = axi_awvalid_in && awready_q;
  wire w_take   = axi_wvalid_in && wready_q;
  wire wr_go    = aw_hold_q && w_hold_q && !bvalid_q;
  wire b_done   = bvalid_q && axi_bready_in;
  wire ar_take  = axi_arvalid_in && arready_q;
  wire r_done   = rvalid_q && axi_rready_in;
  wire wr_ctrl  = wr_go && (awaddr_q == ADDR_CTRL);
  wire wr_stat  = wr_go && (awaddr_q == ADDR_STATUS);
  wire wr_lane0 = wr_ctrl && wstrb_q[0];
  wire [2:0] wr_sel = wdata_q[CTRL_SEL_LSB +: CTRL_SEL_W];
  wire sel_ok   = wr_sel < SEL_NUM;
  wire connect_req = wr_lane0 && wdata_q[CTRL_CONNECT];
  wire rd_ctrl  = axi_araddr_in == ADDR_CTRL;
  wire rd_stat  = axi_araddr_in == ADDR_STATUS;

  // register read views
  wire [31:0] ctrl_view = {26'h0, conn_q, fwupd_q, ident_q, clk_sel_q};
  wire [31:0] stat_view = {25'h0, drop_q, conn_q, suspend_s, host_up_q,
                           vref_ok_q, led_green_out, led_red_out};
  wire [31:0] rd_view   = rd_ctrl ? ctrl_view :
                          (rd_stat ? stat_view : 32'h0);

  // host presence from link clock activity
  wire link_edge = link_s != link_d1_q;
  wire host_lost = host_cnt_q >= HOST_W'(HOST_LOST_CYC);

  // indicator selection
  led_t colour;
  wire  dark   = suspend_s || !host_up_q;
  wire  steady = !ident_q || blink_ph_q;
  assign colour = dark      ? LED_OFF :
                  fwupd_q   ? LED_RED :
                  !steady   ? LED_OFF :
                  vref_ok_q ? LED_GREEN : LED_AMBER; // RULE13

  // write address and data capture
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (aw_take) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b1;
      awaddr_q  <= axi_awaddr_in;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end else if (b_done) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wready_q <= 1'b1;
      w_hold_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (w_take) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b1;
      wdata_q  <= axi_wdata_in;
      wstrb_q  <= axi_wstrb_in;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end else if (b_done) begin
      wready_q <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_view;
      rresp_q   <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      clk_sel_q <= SEL_RST; // RULE2
      ident_q   <= IDENT_RST;
      fwupd_q   <= FWUPD_RST;
    end else if (wr_lane0) begin
      if (sel_ok) begin
        clk_sel_q <= wr_sel; // RULE1 RULE3
      end
      ident_q <= wdata_q[CTRL_IDENT];
      fwupd_q <= wdata_q[CTRL_FWUPD];
    end
  end

  // host connection, dropped on suspend, restored by software
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      conn_q <= CONN_RST;
      drop_q <= 1'b0;
    end else begin
      if (suspend_s) begin
        conn_q <= 1'b0; // RULE12
      end else if (connect_req) begin
        conn_q <= 1'b1;
      end
      if (suspend_s && conn_q) begin
        drop_q <= 1'b1;
      end else if (connect_req) begin
        drop_q <= 1'b0;
      end
    end
  end

  // hysteretic reference detection
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vref_ok_q <= 1'b0;
    end else if (below_s) begin
      vref_ok_q <= 1'b0; // RULE5 RULE7
    end else if (above_s) begin
      vref_ok_q <= 1'b1; // RULE6 RULE7
    end
  end

  // host link watchdog
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      link_d1_q  <= 1'b0;
      host_cnt_q <= HOST_W'(HOST_LOST_CYC);
      host_up_q  <= 1'b0;
    end else begin
      link_d1_q <= link_s;
      if (link_edge) begin
        host_cnt_q <= '0;
      end else if (!host_lost) begin
        host_cnt_q <= host_cnt_q + 1'b1;
      end
      host_up_q <= !host_lost; // RULE9
    end
  end

  // identification blink divider
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !ident_q) begin
      blink_cnt_q <= '0;
      blink_ph_q  <= 1'b1;
    end else if (blink_cnt_q >= BLINK_W'(BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_ph_q  <= !blink_ph_q; // RULE10
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // indicator and driver power
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      led_red_out   <= 1'b0;
      led_green_out <= 1'b0;
      drv_pwr_q     <= 1'b0;
    end else begin
      led_red_out   <= (colour == LED_RED) || (colour == LED_AMBER); // RULE8
      led_green_out <= (colour == LED_GREEN) || (colour == LED_AMBER);
      drv_pwr_q     <= !suspend_s; // RULE11
    end
  end

  cfg_clk_gen u_clk_gen (
    .core_clk_in    (core_clk_in),
    .sys_rst_in     (sys_rst_in),
    .run_in         (conn_q && !suspend_s),
    .sel_in         (clk_sel_q),
    .serial_clk_out (config_serial_clock_out)
  ); // RULE1

  assign target_drv_pwr_out = drv_pwr_q;
  assign axi_awready_out    = awready_q;
  assign axi_wready_out     = wready_q;
  assign axi_bvalid_out     = bvalid_q;
  assign axi_bresp_out      = bresp_q;
  assign axi_arready_out    = arready_q;
  assign axi_rvalid_out     = rvalid_q;
  assign axi_rdata_out      = rdata_q;
  assign axi_rresp_out      = rresp_q;

  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  wire lit_ok = !dark && !fwupd_q;

  chk_sel_legal: assert property ( // RULE1
    clk_sel_q < SEL_NUM)
    else $error("clock selection out of range");

  chk_sel_reset: assert property ( // RULE2
    $fell(sys_rst_in) |-> clk_sel_q == SEL_RST)
    else $error("clock selection not 6 MHz after reset");

  chk_sel_accept: assert property ( // RULE3
    wr_lane0 && sel_ok |=> clk_sel_q == $past(wr_sel))
    else $error("legal clock selection not taken");

  chk_amber_low: assert property ( // RULE5
    lit_ok && steady && !vref_ok_q |=> led_red_out && led_green_out)
    else $error("indicator not amber with low reference");

  chk_green_only: assert property ( // RULE6
    led_green_out && !led_red_out |-> $past(vref_ok_q))
    else $error("green without good reference");

  chk_vref_hyst: assert property ( // RULE7
    !above_s && !below_s |=> $stable(vref_ok_q))
    else $error("reference state moved inside hysteresis band");

  chk_red_fw: assert property ( // RULE8
    !dark && fwupd_q |=> led_red_out && !led_green_out)
    else $error("indicator not red during update");

  chk_dark_susp: assert property ( // RULE9
    suspend_s |=> !led_red_out && !led_green_out)
    else $error("indicator lit during suspend");

  chk_blink_off: assert property ( // RULE10
    lit_ok && ident_q && !blink_ph_q |=> !led_red_out && !led_green_out)
    else $error("indicator lit in blink off phase");

  chk_drv_unpow: assert property ( // RULE11
    suspend_s |=> !target_drv_pwr_out)
    else $error("target drivers powered in suspend");

  chk_conn_drop: assert property ( // RULE12
    suspend_s |=> !conn_q ##1 !config_serial_clock_out)
    else $error("connection kept through suspend");

  chk_sync_path: assert property ( // RULE14
    $rose(vref_ok_q) |-> $past(above_s) && !$past(below_s))
    else $error("reference rose without synchronised level");

  cov_green: cover property (lit_ok && vref_ok_q ##1 led_green_out);
  cov_red: cover property (!dark && fwupd_q ##1 led_red_out);
  cov_blink: cover property (ident_q && $changed(blink_ph_q));
  cov_reconnect: cover property ($fell(conn_q) ##[1:1000] $rose(conn_q));

endmodule

`default_nettype wire

// >>> cable_sync2.sv
/*
 * two flip-flop synchroniser for a group of level inputs.
 * assumes inputs are quasi-static relative to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cable_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  // levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> cfg_clk_gen.sv
/*
 * configuration serial clock generator: a phase accumulator toggles the
 * output at twice the selected rate.
 * assumes the 20 MHz core clock; rates above half of it saturate.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_clk_gen
  import cable_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  // control
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  // serial clock
  output var  logic       serial_clk_out
);

  logic [NCO_W-1:0] acc_q;
  wire  [NCO_W:0]   sum = {1'b0, acc_q} + nco_step(sel_in);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !run_in) begin
      acc_q          <= '0;
      serial_clk_out <= 1'b0;
    end else begin
      acc_q <= sum[NCO_W-1:0];
      if (sum[NCO_W]) begin
        serial_clk_out <= !serial_clk_out;
      end
    end
  end

endmodule

`default_nettype wire

// >>> cfg_target_model.sv
/*
 * target model: reference voltage comparators and serial clock counter.
 * assumes the bench sets the reference in mV and reads the edge count.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_target_model (
  // serial side
  input  wire logic serial_clk_in,
  input  wire logic drv_pwr_in,
  // reference voltage in mV
  input  var  int   vref_mv_in,
  // comparator levels and edge count
  output var  logic above_hi_out,
  output var  logic below_lo_out,
  output var  int   edge_cnt_out
);
  assign above_hi_out = (vref_mv_in > 1500);
  assign below_lo_out = (vref_mv_in < 1300);

  // counts rising clock edges only while the drivers are powered
  always @(posedge serial_clk_in) begin
    if (drv_pwr_in) begin
      edge_cnt_out <= edge_cnt_out + 1;
    end
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
/*
 * testbench for the cable status and clock select block.
 * assumes the target model file and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cable_pkg::*;
;
  logic              clk, rst, susp, link, link_on;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              sclk, drv, red, grn, hi, lo;
  int                vref, ecnt, errors, n_tests;
  logic [31:0]       d;
  logic [1:0]        r;

  cable_status_clk #(.BLINK_CYC(8)) DUT (
    .core_clk_in(clk), .sys_rst_in(rst),
    .vref_above_hi_in(hi), .vref_below_lo_in(lo),
    .host_suspend_in(susp), .host_link_clk_in(link),
    .config_serial_clock_out(sclk), .target_drv_pwr_out(drv),
    .led_red_out(red), .led_green_out(grn),
    .axi_awvalid_in(awvalid), .axi_awaddr_in(awaddr),
    .axi_awready_out(awready), .axi_wvalid_in(wvalid),
    .axi_wdata_in(wdata), .axi_wstrb_in(wstrb), .axi_wready_out(wready),
    .axi_bvalid_out(bvalid), .axi_bresp_out(bresp), .axi_bready_in(bready),
    .axi_arvalid_in(arvalid), .axi_araddr_in(araddr),
    .axi_arready_out(arready), .axi_rvalid_out(rvalid),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rready_in(rready));

  cfg_target_model target (
    .serial_clk_in(sclk), .drv_pwr_in(drv), .vref_mv_in(vref),
    .above_hi_out(hi), .below_lo_out(lo), .edge_cnt_out(ecnt));

  initial clk = 1'b0;
  always #25 clk = ~clk;
  // host link clock stands still while the host is away
  always #200 if (link_on) link = ~link;

  task automatic summarize();
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic chk_near(input int g, input int e);
    n_tests++;
    if (g > e + 2 || g < e - 2) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic led(input logic [1:0] e);
    chk({30'h0, red, grn}, {30'h0, e});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bit aw, w;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hF;
    bready  <= 1'b1;
    aw = 0;
    w  = 0;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic setv(input int mv);
    @(posedge clk);
    vref <= mv;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_reset();
    @(negedge clk);
    led(2'h0);
    chk({31'h0, drv}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL);
    chk({29'h0, d[2:0]}, 32'h2);
    rd(4'h8);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(4'hC, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(ADDR_STATUS, 32'hFF);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic t_colour();
    link_on <= 1'b1;
    repeat (20) @(posedge clk);
    setv(1000);
    led(2'h3);
    setv(1600);
    led(2'h1);
    setv(1400);
    led(2'h1);
    setv(1200);
    led(2'h3);
    setv(1400);
    led(2'h3);
    setv(1600);
    led(2'h1);
    wr(ADDR_CTRL, 32'h10);
    repeat (4) @(posedge clk);
    led(2'h2);
    wr(ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    led(2'h1);
  endtask

  task automatic t_blink();
    int on, off, bad, mv;
    wr(ADDR_CTRL, 32'h08);
    for (int i = 0; i < 2; i++) begin
      mv = (i == 0) ? 1600 : 1000;
      setv(mv);
      on = 0;
      off = 0;
      bad = 0;
      repeat (40) begin
        @(posedge clk);
        if ({red, grn} === ((mv > 1500) ? 2'h1 : 2'h3)) on++;
        else if ({red, grn} === 2'h0) off++;
        else bad++;
      end
      chk({31'h0, on > 0 && off > 0 && bad == 0}, 32'h1);
    end
    wr(ADDR_CTRL, 32'h0);
    setv(1600);
  endtask

  task automatic t_rates();
    int khz[6] = '{24000, 12000, 6000, 3000, 1500, 750};
    int n0;
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_CTRL, 32'h20 | s);
      repeat (20) @(posedge clk);
      n0 = ecnt;
      repeat (2000) @(posedge clk);
      chk_near(ecnt - n0, ((khz[s] > 10000) ? 10000 : khz[s]) / 10);
    end
    wr(ADDR_CTRL, 32'h26);
    rd(ADDR_CTRL);
    chk({26'h0, d[5:0]}, 32'h25);
  endtask

  task automatic t_suspend();
    int n0, hi_seen;
    chk({31'h0, drv}, 32'h1);
    @(posedge clk);
    susp <= 1'b1;
    repeat (10) @(posedge clk);
    led(2'h0);
    chk({31'h0, drv}, 32'h0);
    n0 = ecnt;
    hi_seen = 0;
    repeat (200) begin
      @(posedge clk);
      if (sclk !== 1'b0) hi_seen++;
    end
    chk_near(ecnt - n0, 0);
    chk(hi_seen, 32'h0);
    @(posedge clk);
    susp <= 1'b0;
    repeat (10) @(posedge clk);
    rd(ADDR_STATUS);
    chk({30'h0, d[ST_DROP], d[ST_CONN]}, 32'h2);
    wr(ADDR_CTRL, 32'h25);
    rd(ADDR_STATUS);
    chk({30'h0, d[ST_DROP], d[ST_CONN]}, 32'h1);
    @(posedge clk);
    link_on <= 1'b0;
    repeat (60) @(posedge clk);
    led(2'h0);
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    susp = 1'b0;
    link = 1'b0;
    link_on = 1'b0;
    vref = 0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    // reset is released by t_reset at the fifth rising edge
    repeat (4) @(posedge clk);
    t_reset();
    t_colour();
    t_blink();
    t_rates();
    t_suspend();
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule

`default_nettype wire
